// ==== acp_pkg.sv ====
/*
 * Shared constants of the converter serial port and conversion control:
 * configuration field layout, reset values, frame lengths, timing counts
 * and the conversion state encoding.
 * Assumes a 50 MHz system clock; all timing counts derive from that rate.
 */
package acp_pkg;

   // Clock rate of the internal logic
   localparam int unsigned SYS_CLK_HZ = 50_000_000;
   localparam int unsigned SYS_CLK_PER_US = SYS_CLK_HZ / 1_000_000;

   // Configuration word layout
   localparam int unsigned CFG_W = 16;
   localparam logic [15:0] CFG_RESET = 16'h058b;
   localparam int unsigned SS_BIT = 15;
   localparam int unsigned MODE_BIT = 8;
   localparam int unsigned TS_BIT = 4;
   localparam int unsigned PUE_BIT = 3;
   localparam int unsigned NOP_HI = 2;
   localparam int unsigned NOP_LO = 1;
   localparam int unsigned RSV_BIT = 0;
   localparam logic [1:0] NOP_VALID = 2'h1;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Temperature result: 14-bit code left-justified in 16 bits
   localparam int unsigned TEMP_W = 14;
   localparam int unsigned TEMP_PAD = 2;

   // Frame lengths in serial clocks
   localparam logic [5:0] FRAME_HALF = 6'h10;
   localparam logic [5:0] FRAME_LONG = 6'h20;
   localparam logic [4:0] FALL_LAST = 5'h0f;

   // Serial clock idle timeout: 28 ms, longest time, rounded down
   localparam int unsigned TIMEOUT_MS = 28;
   localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * (SYS_CLK_HZ / 1000);

   // Ready line returns high this long before the next result
   localparam int unsigned DRDY_LEAD_US = 8;
   localparam int unsigned DRDY_LEAD_CYCLES = DRDY_LEAD_US * SYS_CLK_PER_US;

   // Duration of one conversion (front end stand-in)
   localparam int unsigned CONV_TIME_US = 1200;
   localparam int unsigned CONV_CYCLES = CONV_TIME_US * SYS_CLK_PER_US;

   // Counter width for the long counts
   localparam int unsigned CNT_W = 24;

   // Conversion sequencer states
   typedef enum logic [0:0] {
      ST_POWER_DOWN = 1'b0,
      ST_CONVERT = 1'b1
   } acp_state_type;

endpackage : acp_pkg

// ==== acp_sync.sv ====
/*
 * Two flip-flop level synchroniser, a vector of independent bits.
 * Assumes each bit is a level or a toggle that stays put for at least
 * two destination clocks; no grouping of bits into words is implied.
 */
`timescale 1ns/1ps
module acp_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : acp_sync

// ==== acp_serial_ctrl.sv ====
/*
 * Serial port and conversion control of a delta-sigma converter.
 * The link side runs on the host serial clock (data in on falling
 * edges, data out on rising edges); configuration, sequencing and the
 * ready flag run on the internal clock. Words cross by toggle plus
 * quasi-static hold.
 * Assumes: the host waits three internal clocks after chip select falls
 * before its first serial clock edge, and keeps the serial clock low
 * while idle. Analog results arrive on plain inputs.
 */
// Notes on behaviour
// - Positive temperature: 14-bit left-justified, sign zero
// - Negative temperature: invert magnitude, add one
// - Power-up reset restores configuration defaults
// - Starts powered down, interface still alive
// - Mode one: single-shot, powered down between
// - Trigger bit: convert once, clear, power down
// - Trigger during conversion is ignored
// - Mode zero: convert back to back continuously
// - Leave continuous by mode write or reset
// - Select high: reset port, release line
// - Select falls: line shows unread data
// - Result frozen for the whole transfer
// - Clock low 28 ms resets the port
// - Sample data in on falling edges
// - Shift data out on rising edges
// - Line low means result waiting
// - Mode zero: line high 8 us before each result
// - Pullup while deselected, unless disabled
// - Bit 15 first; configuration captured alongside
// - Frames of 16 or 32 with echo
// - Configuration resets to 058b
`timescale 1ns/1ps
module acp_serial_ctrl
   import acp_pkg::*;
#(
   parameter logic [acp_pkg::CNT_W-1:0] TIMEOUT_LEN = acp_pkg::CNT_W'(acp_pkg::TIMEOUT_CYCLES),
   parameter logic [acp_pkg::CNT_W-1:0] CONV_LEN = acp_pkg::CNT_W'(acp_pkg::CONV_CYCLES),
   parameter logic [acp_pkg::CNT_W-1:0] DRDY_LEAD = acp_pkg::CNT_W'(acp_pkg::DRDY_LEAD_CYCLES)
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic data_out_ready_line,
   output logic data_out_ready_line_oe,
   output logic data_out_pullup_on,
   input wire logic [15:0] adc_code,
   input wire logic [acp_pkg::TEMP_W-1:0] temp_magnitude,
   input wire logic temp_negative,
   output logic [15:0] config_word,
   output logic [15:0] conversion_result,
   output logic powered_up
);
   import acp_pkg::*;

   // Sign-encode a temperature and left-justify it
   function automatic logic [15:0] temp_encode(input logic neg, input logic [TEMP_W-1:0] mag);
      logic [TEMP_W-1:0] code;
      code = neg ? (~mag + TEMP_W'(1)) : mag;
      return {code, {TEMP_PAD{1'b0}}};
   endfunction : temp_encode

   // Internal clock state
   logic [15:0] cfg, next_cfg;
   logic [15:0] result, next_result;
   logic [15:0] snap, next_snap;
   acp_state_type state, next_state;
   logic [CNT_W-1:0] conv_cnt, next_conv_cnt;
   logic ready, next_ready;
   logic ss_pend, next_ss_pend;
   logic [CNT_W-1:0] to_cnt, next_to_cnt;
   logic to_pulse, next_to_pulse;
   logic rise_seen, cfg_seen;

   // Link state, rising edge
   logic [5:0] bit_cnt, next_bit_cnt;
   logic [14:0] out_sr, next_out_sr;
   logic dout_q, next_dout_q;
   logic started, next_started;
   logic rise_tgl, next_rise_tgl;

   // Link state, falling edge
   logic [15:0] in_sr, next_in_sr;
   logic [4:0] fall_cnt, next_fall_cnt;
   logic [15:0] rx_word, next_rx_word;
   logic rx_tgl, next_rx_tgl;
   logic in_done, next_in_done;

   // Crossing wires
   logic [2:0] sync_q;
   logic cs_s, rise_s, rx_s;
   logic link_rst_n;
   logic conv_done, write_ok;

   acp_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h4)
   ) u_sync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .async_in({cs_n, rise_tgl, rx_tgl}),
      .sync_out(sync_q)
   );
   assign cs_s = sync_q[2];

   // Edge memory for the two toggles, reads only synchronised bits
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_s <= 1'b0;
         rx_s <= 1'b0;
      end else begin
         rise_s <= sync_q[1];
         rx_s <= sync_q[0];
      end
   end
   assign rise_seen = sync_q[1] ^ rise_s;
   assign cfg_seen = sync_q[0] ^ rx_s;

   // Port reset: deselect, timeout or system reset
   // select high clears port
   assign link_rst_n = rst_n & ~cs_n & ~to_pulse;

   assign conv_done = (state == ST_CONVERT) && (conv_cnt == CONV_LEN - CNT_W'(1));
   // Writes take effect only when the no-op field marks them valid
   assign write_ok = cfg_seen && (rx_word[NOP_HI:NOP_LO] == NOP_VALID);

   // Configuration, sequencer and ready flag
   always_comb begin
      next_cfg = cfg;
      next_result = result;
      next_snap = snap;
      next_state = state;
      next_conv_cnt = conv_cnt;
      next_ready = ready;
      next_ss_pend = ss_pend;
      if (write_ok) begin
         next_cfg = rx_word;
         next_cfg[RSV_BIT] = 1'b1;
         next_cfg[SS_BIT] = 1'b0;
         if (rx_word[SS_BIT] && (state == ST_POWER_DOWN)) begin
            next_ss_pend = 1'b1;
         end
      end
      case (state)
         ST_POWER_DOWN: begin
            next_conv_cnt = '0;
            // mode one waits for a trigger
            if (!cfg[MODE_BIT] || ss_pend) begin
               next_state = ST_CONVERT;
               next_ss_pend = 1'b0;
            end
         end
         ST_CONVERT: begin
            next_conv_cnt = conv_cnt + CNT_W'(1);
            if (conv_done) begin
               next_conv_cnt = '0;
               next_result = cfg[TS_BIT] ? temp_encode(temp_negative, temp_magnitude) : adc_code;
               if (cfg[MODE_BIT]) begin
                  next_state = ST_POWER_DOWN;
               end
            end
         end
         default: begin
            next_state = ST_POWER_DOWN;
         end
      endcase
      if ((state == ST_CONVERT) && !cfg[MODE_BIT] && (conv_cnt == CONV_LEN - CNT_W'(1) - DRDY_LEAD)) begin
         next_ready = 1'b0;
      end
      // First clock of a transfer counts as reading the result
      if (rise_seen && !cs_s) begin
         next_ready = 1'b0;
      end
      // new result sets ready, set wins
      if (conv_done) begin
         next_ready = 1'b1;
      end
      // result frozen while selected
      // Idle port after a timeout follows too, so a tied-low select sees new data;
      // a result landing at the very first edge of such a frame is not guarded
      if (cs_s || (to_cnt == TIMEOUT_LEN)) begin
         next_snap = result;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= CFG_RESET;
         result <= RESULT_RESET;
         snap <= RESULT_RESET;
         state <= ST_POWER_DOWN;
         conv_cnt <= '0;
         ready <= 1'b0;
         ss_pend <= 1'b0;
      end else begin
         cfg <= next_cfg;
         result <= next_result;
         snap <= next_snap;
         state <= next_state;
         conv_cnt <= next_conv_cnt;
         ready <= next_ready;
         ss_pend <= next_ss_pend;
      end
   end

   // Idle timeout counted here: a stopped serial clock has no edges to count on
   always_comb begin
      next_to_cnt = to_cnt;
      next_to_pulse = 1'b0;
      if (rise_seen) begin
         next_to_cnt = '0;
      end else if (to_cnt != TIMEOUT_LEN) begin
         next_to_cnt = to_cnt + CNT_W'(1);
         next_to_pulse = (to_cnt == TIMEOUT_LEN - CNT_W'(1));
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         to_cnt <= '0;
         to_pulse <= 1'b0;
      end else begin
         to_cnt <= next_to_cnt;
         to_pulse <= next_to_pulse;
      end
   end

   // Output shifter on rising serial edges; snap and rx_word are held still while read
   always_comb begin
      next_started = 1'b1;
      next_rise_tgl = ~rise_tgl;
      next_bit_cnt = (bit_cnt == FRAME_LONG) ? bit_cnt : bit_cnt + 6'h01;
      next_out_sr = {out_sr[13:0], 1'b0};
      next_dout_q = out_sr[14];
      if (bit_cnt == 6'h00) begin
         next_dout_q = snap[15];
         next_out_sr = snap[14:0];
      end else if (bit_cnt == FRAME_HALF) begin
         next_dout_q = rx_word[15];
         next_out_sr = rx_word[14:0];
      end else if (bit_cnt == FRAME_LONG) begin
         next_dout_q = 1'b0;
      end
   end

   // data out moves on rising edge
   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_cnt <= 6'h00;
         out_sr <= 15'h0000;
         dout_q <= 1'b1;
         started <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         out_sr <= next_out_sr;
         dout_q <= next_dout_q;
         started <= next_started;
      end
   end

   // Activity toggle survives port resets so no edge is lost
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         rise_tgl <= 1'b0;
      end else begin
         rise_tgl <= next_rise_tgl;
      end
   end

   // Input shifter; a word completes on the sixteenth falling edge
   always_comb begin
      next_in_sr = {in_sr[14:0], din};
      next_fall_cnt = (fall_cnt == FALL_LAST) ? fall_cnt : fall_cnt + 5'h01;
      next_rx_word = rx_word;
      next_rx_tgl = rx_tgl;
      if ((fall_cnt == FALL_LAST) && !in_done) begin
         next_rx_word = next_in_sr;
         next_rx_tgl = ~rx_tgl;
      end
   end

   // Marks the word taken, so later edges of a long frame add nothing
   always_comb begin
      next_in_done = in_done | (fall_cnt == FALL_LAST);
   end

   // data in sampled on falling edge
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         in_sr <= 16'h0000;
         fall_cnt <= 5'h00;
         in_done <= 1'b0;
      end else begin
         in_sr <= next_in_sr;
         fall_cnt <= next_fall_cnt;
         in_done <= next_in_done;
      end
   end

   // Received word and its toggle outlive the frame for the crossing
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_word <= CFG_RESET;
         rx_tgl <= 1'b0;
      end else begin
         rx_word <= next_rx_word;
         rx_tgl <= next_rx_tgl;
      end
   end

   // Pin drive follows the raw select so the ready level shows at once
   // ready shown before first edge
   assign data_out_ready_line = started ? dout_q : ~ready;
   assign data_out_ready_line_oe = ~cs_n;
   assign data_out_pullup_on = cs_n & cfg[PUE_BIT];

   assign config_word = cfg;
   assign conversion_result = result;
   assign powered_up = (state == ST_CONVERT);

endmodule : acp_serial_ctrl

// ==== acp_serial_ctrl_chk.sv ====
/*
 * Port-level checker of the converter serial port and sequencer.
 * Assumes binding to acp_serial_ctrl and a single internal clock.
 */
`timescale 1ns/1ps
module acp_serial_ctrl_chk
   import acp_pkg::*;
#(
   parameter logic [acp_pkg::CNT_W-1:0] CONV_LEN = acp_pkg::CNT_W'(acp_pkg::CONV_CYCLES)
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic data_out_ready_line_oe,
   input wire logic data_out_pullup_on,
   input wire logic [15:0] config_word,
   input wire logic [15:0] conversion_result,
   input wire logic powered_up
);
   import acp_pkg::*;
   logic [CNT_W-1:0] cnt, next_cnt;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Single-shot busy time; continuous runs are not bounded
   always_comb begin
      next_cnt = (powered_up && config_word[MODE_BIT]) ? cnt + 1'b1 : '0;
   end
   // Counter register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
   sequence s_release;
      $rose(rst_n);
   endsequence
   sequence s_shot_done;
      $fell(powered_up) && config_word[MODE_BIT];
   endsequence
   AST_CFG_RESET: assert property (s_release |-> config_word == CFG_RESET)
      else $error("config word not at default after reset");
   AST_IDLE_RESET: assert property (s_release |-> conversion_result == RESULT_RESET && !powered_up)
      else $error("not idle after reset");
   AST_OE: assert property (data_out_ready_line_oe == !cs_n)
      else $error("output enable does not follow select");
   AST_PULLUP: assert property (data_out_pullup_on == (cs_n && config_word[PUE_BIT]))
      else $error("pullup state wrong");
   AST_SHOT_LEN: assert property (cnt <= CONV_LEN + 8)
      else $error("single-shot conversion too long");
   AST_SHOT_REST: assert property (s_shot_done |=> !powered_up [*3])
      else $error("restarted without trigger");
   AST_SS_CLEAR: assert property ($rose(powered_up) && config_word[MODE_BIT] |-> ##[0:4] !config_word[SS_BIT])
      else $error("trigger bit not cleared");
   AST_CONT_HOLD: assert property (!config_word[MODE_BIT] && powered_up |=> powered_up)
      else $error("continuous mode powered down");
   AST_CONT_START: assert property (!config_word[MODE_BIT] |-> ##[0:8] powered_up)
      else $error("continuous mode did not start");
   AST_RESULT_HOLD: assert property (!powered_up && !$past(powered_up) && !$past(powered_up, 2)
      |-> $stable(conversion_result))
      else $error("result changed while powered down");
endmodule : acp_serial_ctrl_chk

bind acp_serial_ctrl acp_serial_ctrl_chk #(.CONV_LEN(CONV_LEN)) u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .data_out_ready_line_oe(data_out_ready_line_oe),
   .data_out_pullup_on(data_out_pullup_on), .config_word(config_word),
   .conversion_result(conversion_result), .powered_up(powered_up));

// ==== acp_host_model.sv ====
/*
 * Host controller model: chip select, serial clock and data in.
 * Assumes the bench resolves the data/ready wire into line.
 */
`timescale 1ns/1ps
module acp_host_model (
   input wire logic sys_clk,
   input wire logic line,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   // select, n clocks of 6 ns, optional keep-low
   task automatic xfer(input logic [31:0] tx, input int n, input logic keep,
                       output logic rdy, output logic [31:0] rx);
      int i;
      @(posedge sys_clk) cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 rdy = line;
      rx = '0;
      for (i = 0; i < n; i++) begin
         sclk = 1'b1;
         din = tx[n-1-i];
         #3 rx = {rx[30:0], line};
         sclk = 1'b0;
         #3;
      end
      // host decides spacing; din shows no stale value
      @(posedge sys_clk) cs_n <= keep ? 1'b0 : 1'b1;
      din <= ~din;
   endtask : xfer
endmodule : acp_host_model

// ==== test_adc_serial_port_and_conversion_control.sv ====
/*
 * Self-checking bench of acp_serial_ctrl with a host model.
 * Assumes short counts: timeout 200, conversion 600, lead 40 cycles.
 */
`timescale 1ns/1ps
module test_adc_serial_port_and_conversion_control;
   import acp_pkg::*;
   localparam int CONV = 600;
   logic sys_clk, rst_n, cs_n, sclk, din, dout, oe, pu, temp_negative, powered_up, line_w, last_v, rdy;
   logic [15:0] adc_code, config_word, conversion_result;
   logic [13:0] temp_magnitude;
   logic [31:0] rx;
   logic [30:0] rows [4] = '{{14'h0640, 1'b0, 16'h1900}, {14'h0320, 1'b1, 16'hf380},
                             {14'h0001, 1'b0, 16'h0004}, {14'h0008, 1'b1, 16'hffe0}};
   int err_total = 0, total_checks = 0, cyc = 0, k, k2, i;
   logic hit;
   // Released wire: pullup or a toggling float
   assign line_w = oe ? dout : (pu ? 1'b1 : ~last_v);
   always @(posedge sys_clk) last_v <= line_w;
   acp_serial_ctrl #(.TIMEOUT_LEN(24'h0000c8), .CONV_LEN(24'h000258), .DRDY_LEAD(24'h000028)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
      .data_out_ready_line(dout), .data_out_ready_line_oe(oe), .data_out_pullup_on(pu),
      .adc_code(adc_code), .temp_magnitude(temp_magnitude), .temp_negative(temp_negative),
      .config_word(config_word), .conversion_result(conversion_result), .powered_up(powered_up));
   acp_host_model u_host (.sys_clk(sys_clk), .line(line_w), .cs_n(cs_n), .sclk(sclk), .din(din));
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: word %h expected %h", $time, g, e);
      end
   endtask : chk16
   task automatic chk1(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: flag %b expected %b", $time, g, e);
      end
   endtask : chk1
   // Bounded wait for powered_up (sel 0) or the wire (sel 1) to reach v
   task automatic wait_for(input int sel, input logic v, output int n);
      n = 0;
      while ((sel ? line_w : powered_up) !== v && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : wait_for
   task automatic wr(input logic [15:0] c);
      u_host.xfer({16'h0000, c}, 16, 1'b0, rdy, rx);
      repeat (8) @(posedge sys_clk);
   endtask : wr
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      adc_code = 16'h1234;
      temp_magnitude = '0;
      temp_negative = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (50) @(posedge sys_clk);
      chk16(config_word, CFG_RESET);
      chk16(conversion_result, RESULT_RESET);
      chk1(powered_up, 1'b0);
      chk1(line_w, 1'b1);
      wr(16'h0000);
      chk1(rdy, 1'b1);
      chk16(config_word, CFG_RESET);
      for (i = 0; i < 4; i++) begin
         {temp_magnitude, temp_negative} <= rows[i][30:16];
         wr(16'h859b);
         chk1(powered_up, 1'b1);
         chk16(config_word, 16'h059b);
         wait_for(0, 1'b0, k);
         chk16(conversion_result, rows[i][15:0]);
         u_host.xfer({16'h059b, 16'h059b}, 32, 1'b0, rdy, rx);
         chk1(rdy, 1'b0);
         chk16(rx[31:16], rows[i][15:0]);
         chk16(rx[15:0], 16'h059b);
      end
      wr(16'h859b);
      repeat (100) @(posedge sys_clk);
      wr(16'h859b);
      wait_for(0, 1'b0, k);
      chk1(k < CONV - 60, 1'b1);
      hit = 1'b0;
      repeat (CONV + 100) @(negedge sys_clk) hit |= powered_up;
      chk1(hit, 1'b0);
      wr(16'h0583);
      chk1(pu, 1'b0);
      wr(16'h048b);
      chk1(powered_up, 1'b1);
      u_host.xfer(32'h0, 0, 1'b1, rdy, rx);
      wait_for(1, 1'b0, k);
      chk16(conversion_result, adc_code);
      wait_for(1, 1'b1, k);
      wait_for(1, 1'b0, k2);
      chk1(k2 >= 38 && k2 <= 42, 1'b1);
      chk1(k + k2 >= CONV - 3 && k + k2 <= CONV + 3, 1'b1);
      u_host.xfer(32'h0, 5, 1'b1, rdy, rx);
      repeat (220) @(posedge sys_clk);
      u_host.xfer({16'h058b, 16'h058b}, 32, 1'b0, rdy, rx);
      chk16(rx[15:0], 16'h058b);
      chk16(rx[31:16], adc_code);
      wait_for(0, 1'b0, k);
      chk1(powered_up, 1'b0);
      wr(16'h048b);
      repeat (50) @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk16(config_word, CFG_RESET);
      rst_n <= 1'b1;
      repeat (50) @(posedge sys_clk);
      chk1(powered_up, 1'b0);
      conclude();
   end
endmodule : test_adc_serial_port_and_conversion_control
